// ==== design/lbi_pkg.sv ====
// shared constants of the local bus interface and its host end
package lbi_pkg;
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned RATE_AUTO_BPS = 340_000;
  localparam int unsigned RATE_IBC_BPS  = 250_000;
  // half a bit cycle, rounded down so the rate is never undershot
  localparam int unsigned HALF_AUTO     = CLK_HZ / RATE_AUTO_BPS / 2;
  localparam int unsigned HALF_IBC      = CLK_HZ / RATE_IBC_BPS / 2;
  localparam int unsigned HALF_W        = 10;
  localparam int unsigned IDLE_BITS     = 4;
  localparam int unsigned IDLE_CYC      = IDLE_BITS * 2 * HALF_IBC;
  localparam int unsigned IDLE_W        = 12;
  localparam int unsigned MAX_PARTICIPANTS = 9;
  localparam int unsigned ROW_BITS      = 9;

  // device register indices on the peripheral port
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_TXDATA = 3'h1;
  localparam logic [2:0] REG_RXDATA = 3'h2;
  localparam logic [2:0] REG_ALARM  = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h4;
  localparam logic [2:0] REG_CMD    = 3'h5;
  localparam logic [2:0] REG_STRAPS = 3'h6;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam int unsigned CTRL_EN   = 0;
  localparam int unsigned CTRL_IBC  = 1;
  localparam int unsigned CMD_SEND  = 0;
  localparam int unsigned CMD_RESET = 1;
  localparam int unsigned CMD_ACK   = 2;
  localparam int unsigned STAT_ERR  = 3;
  localparam int unsigned STAT_RXE  = 4;
  localparam int unsigned STAT_TXF  = 5;
  localparam int unsigned STAT_MSG  = 6;
  localparam int unsigned STAT_BUSY = 7;

  // local bus pin vector: clock, qualifier, data of bus a then bus b
  localparam int unsigned LB_T = 0;
  localparam int unsigned LB_B = 1;
  localparam int unsigned LB_D = 2;
  localparam int unsigned LB_BUS_B = 3;

  // host end axi4-lite offsets
  localparam logic [7:0] H_CMD      = 8'h00;
  localparam logic [7:0] H_RESULT   = 8'h04;
  localparam logic [7:0] H_BUF_STAT = 8'h08;
  localparam logic [7:0] H_BUF_BASE = 8'h40;
  localparam int unsigned H_CMD_WR  = 16;

  typedef enum logic [2:0] {
    transfer_reset_state, transfer_idle_state, transfer_wait_state, transfer_abort_state
  } lp_state_e;
endpackage

// ==== design/lbi_periph_if.sv ====
// peripheral access port between host end and bus interface
`timescale 1ns/1ps
interface lbi_periph_if;
  logic       sel;
  logic       wr;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       ack;
  modport host (output sel, output wr, output addr, output wdata, input rdata, input ack);
  modport dev  (input sel, input wr, input addr, input wdata, output rdata, output ack);
endinterface

// ==== design/local_bus_interface.sv ====
// local bus interface: registers, fifos, line protocol controller
// Notes on behaviour
// - host reaches everything as a peripheral
// - control register selects operating functions
// - transmit fifo sent bit-serially on bus
// - received bits assembled into receive fifo
// - host reads receive fifo byte by byte
// - host forwards only after whole message
// - alarm register request sent on alarm channel
// - status register shows line protocol state
// - own transmission read back and compared
// - row and column parity, distance four
// - 340 kbit/s autonomous, 250 via converter
// - half duplex, no receive while sending
// - redundant wired-or output on two buses
// - at most nine participants per segment
// - addresses and redundancy taken from straps
// - reset state until bus idle seen
// - start, data or flags, stops, back idle
// - abort left only by reset
// - bus zero with participant zero forbidden; straps of 0 and 0 are taken without any check
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module lbi_fifo #(
  parameter int unsigned DEPTH = 16
) (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       push,
  input  wire logic [7:0] din,
  input  wire logic       pop,
  output logic      [7:0] dout,
  output logic            empty,
  output logic            full
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [7:0]  mem_q [DEPTH];
  logic [AW:0] wp_q, rp_q;
  wire         do_push = push & ~full;
  wire         do_pop  = pop & ~empty;
  assign empty = (wp_q == rp_q);
  assign full  = (wp_q[AW-1:0] == rp_q[AW-1:0]) & (wp_q[AW] != rp_q[AW]);
  assign dout  = mem_q[rp_q[AW-1:0]];
  always_ff @(posedge mclk) begin
    if (do_push) mem_q[wp_q[AW-1:0]] <= din;
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_q + (AW+1)'(do_push);
      rp_q <= rp_q + (AW+1)'(do_pop);
    end
  end
endmodule // lbi_fifo

module local_bus_interface
  import lbi_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH  = 16,
  parameter int unsigned BUS_ADDR_W  = 4,
  parameter int unsigned PART_ADDR_W = 4
) (
  input  wire logic                   mclk,
  input  wire logic                   arst_n,
  lbi_periph_if.dev                   pb,
  input  wire logic [BUS_ADDR_W-1:0]  strap_bus_addr,
  input  wire logic [PART_ADDR_W-1:0] strap_part_addr,
  input  wire logic                   strap_redundant,
  input  wire logic [5:0]             lb_i,
  output logic      [5:0]             lb_o,
  output logic      [5:0]             lb_oe_n
);
  typedef enum logic [2:0] {tx_off, tx_start, tx_kind, tx_bits, tx_stop_data, tx_stop_xfer} tx_e;

  ////////////////////////////////////////////////////////////////////////
  // register access
  logic [7:0] ctrl_q, alarm_q, rdata_q, straps_q;
  logic       ack_q, strap_done_q, redund_q;
  logic       send_q, alarm_pend_q, msg_q, err_q;
  lp_state_e  lp_q;
  tx_e        tx_q;
  wire        acc    = pb.sel & ~ack_q;
  wire        wr_acc = acc & pb.wr;
  wire        rd_acc = acc & ~pb.wr;
  wire        wr_cmd = wr_acc & (pb.addr == REG_CMD);
  wire        sw_rst = wr_cmd & pb.wdata[CMD_RESET];
  wire        txf_empty, txf_full, rxf_empty, rxf_full;
  wire [7:0]  txf_dout, rxf_dout;
  wire        tx_act = (tx_q != tx_off);
  wire [7:0]  status = {tx_act, msg_q, txf_full, rxf_empty, err_q, lp_q};
  wire [7:0]  rd_mux = (pb.addr == REG_CTRL)   ? ctrl_q :
                       (pb.addr == REG_RXDATA) ? rxf_dout :
                       (pb.addr == REG_ALARM)  ? alarm_q :
                       (pb.addr == REG_STATUS) ? status :
                       (pb.addr == REG_STRAPS) ? straps_q : 8'h00;
  assign pb.ack   = ack_q;
  assign pb.rdata = rdata_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q   <= 1'b0;
      rdata_q <= 8'h00;
      ctrl_q  <= CTRL_RST;
      alarm_q <= 8'h00;
    end else begin
      ack_q <= acc;
      if (rd_acc) rdata_q <= rd_mux;
      if (wr_acc && pb.addr == REG_CTRL) ctrl_q <= pb.wdata;
      if (wr_acc && pb.addr == REG_ALARM) alarm_q <= pb.wdata;
    end
  end

  // straps are caught once, at the first edge after reset release
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      strap_done_q <= 1'b0;
      straps_q     <= 8'h00;
      redund_q     <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      straps_q     <= 8'({strap_bus_addr, strap_part_addr});
      redund_q     <= strap_redundant;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fifos
  logic [7:0] held_q;
  logic       have_q, rx_push;
  logic       tx_pop;
  lbi_fifo #(.DEPTH(FIFO_DEPTH)) u_txf (
    .mclk  (mclk),
    .arst_n(arst_n),
    .push  (wr_acc & (pb.addr == REG_TXDATA)),
    .din   (pb.wdata),
    .pop   (tx_pop),
    .dout  (txf_dout),
    .empty (txf_empty),
    .full  (txf_full)
  );
  lbi_fifo #(.DEPTH(FIFO_DEPTH)) u_rxf (
    .mclk  (mclk),
    .arst_n(arst_n),
    .push  (rx_push),
    .din   (held_q),
    .pop   (rd_acc & (pb.addr == REG_RXDATA)),
    .dout  (rxf_dout),
    .empty (rxf_empty),
    .full  (rxf_full)
  );

  ////////////////////////////////////////////////////////////////////////
  // line sampling
  logic [5:0] s1_q, s2_q;
  logic       t_prev_q;
  // bus b only counts when strapped redundant
  wire [2:0] ln = s2_q[2:0] | (s2_q[5:3] & {3{redund_q}});
  wire       ln_t = ln[LB_T];
  wire       ln_b = ln[LB_B];
  wire       ln_d = ln[LB_D];
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q     <= 6'h00;
      s2_q     <= 6'h00;
      t_prev_q <= 1'b0;
    end else begin
      s1_q     <= lb_i;
      s2_q     <= s1_q;
      t_prev_q <= ln_t;
    end
  end
  wire       rise = ln_t & ~t_prev_q;
  wire       quiet = ~(ln_t | ln_b | ln_d);
  logic [IDLE_W-1:0] qcnt_q;
  wire       idle_seen = (qcnt_q == IDLE_W'(IDLE_CYC));

  ////////////////////////////////////////////////////////////////////////
  // receiver: active only while not sending
  logic [8:0] sh_q;
  logic [7:0] col_q;
  logic [3:0] bitn_q;
  logic       first_q, kind_q;
  wire        rx_on   = ~tx_act & (lp_q == transfer_wait_state) & rise;
  wire        stop_dt = rx_on & ln_b & ~ln_d;
  wire        stop_xf = rx_on & ln_b & ln_d;
  wire        row_ok  = (bitn_q == 4'(ROW_BITS)) & ~(^sh_q);
  wire        rx_bad  = (rx_on & ~ln_b & ~first_q & (bitn_q == 4'(ROW_BITS))) |
                        (stop_dt & (~row_ok | (have_q & ~kind_q & rxf_full))) |
                        (stop_xf & ((bitn_q != 4'h0) | (col_q != 8'h00) | ~have_q));
  assign rx_push = stop_dt & row_ok & have_q & ~kind_q & ~rxf_full;

  ////////////////////////////////////////////////////////////////////////
  // transmitter and bit timing
  logic [HALF_W-1:0] tcnt_q;
  logic       thi_q, flag_q, chk_q, fsent_q;
  logic [8:0] txsh_q;
  logic [7:0] txcol_q;
  logic [3:0] txn_q;
  wire [HALF_W-1:0] half = ctrl_q[CTRL_IBC] ? HALF_W'(HALF_IBC) : HALF_W'(HALF_AUTO);
  wire        sym_end  = tx_act & thi_q & (tcnt_q == half - 1'b1);
  wire        drv_b    = (tx_q == tx_start) | (tx_q == tx_stop_data) | (tx_q == tx_stop_xfer);
  wire        drv_d    = (tx_q == tx_start) | (tx_q == tx_stop_xfer) |
                         ((tx_q == tx_kind) & flag_q) | ((tx_q == tx_bits) & txsh_q[0]);
  wire        mismatch = sym_end & ((ln_b != drv_b) | (ln_d != drv_d));
  wire        more     = flag_q ? (~fsent_q | ~chk_q) : (~txf_empty | ~chk_q);
  wire [7:0]  nbyte    = (flag_q & ~fsent_q) ? alarm_q :
                         (~flag_q & ~txf_empty) ? txf_dout : txcol_q;
  wire        load     = sym_end & ~mismatch & ((tx_q == tx_kind) | ((tx_q == tx_stop_data) & more));
  wire        go       = ~tx_act & (lp_q == transfer_idle_state) & ctrl_q[CTRL_EN] &
                         (send_q | alarm_pend_q) & quiet;
  assign tx_pop = load & ~flag_q & ~txf_empty;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_q <= tx_off;
      tcnt_q <= '0;
      thi_q <= 1'b0;
      flag_q <= 1'b0;
      chk_q <= 1'b0;
      fsent_q <= 1'b0;
      txsh_q <= 9'h000;
      txcol_q <= 8'h00;
      txn_q <= 4'h0;
    end else if (sw_rst || mismatch) begin
      tx_q <= tx_off;
      thi_q <= 1'b0;
      tcnt_q <= '0;
    end else if (go) begin
      tx_q <= tx_start;
      flag_q <= alarm_pend_q; // alarm request takes precedence
      chk_q <= 1'b0;
      fsent_q <= 1'b0;
      txcol_q <= 8'h00;
      tcnt_q <= '0;
    end else if (tx_act) begin
      tcnt_q <= (tcnt_q == half - 1'b1) ? '0 : tcnt_q + 1'b1;
      if (tcnt_q == half - 1'b1) thi_q <= ~thi_q;
      if (load) begin
        txsh_q <= {^nbyte, nbyte};
        txcol_q <= txcol_q ^ nbyte;
        txn_q <= 4'h0;
        if (flag_q & ~fsent_q) fsent_q <= 1'b1;
        else if (flag_q | txf_empty) chk_q <= 1'b1;
      end
      if (sym_end) begin
        case (tx_q)
          tx_start: tx_q <= tx_kind;
          tx_kind: tx_q <= tx_bits;
          tx_bits: begin
            txsh_q <= {1'b0, txsh_q[8:1]};
            txn_q <= txn_q + 4'h1;
            if (txn_q == 4'(ROW_BITS - 1)) tx_q <= tx_stop_data;
          end
          tx_stop_data: tx_q <= more ? tx_bits : tx_stop_xfer;
          default: tx_q <= tx_off;
        endcase
      end
    end
  end

  // wired-or pins: drive high, release for low; bus b only if redundant
  wire [2:0] drv = {drv_d, drv_b, thi_q} & {3{tx_act}};
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lb_o    <= 6'h00;
      lb_oe_n <= 6'h3f;
    end else begin
      lb_o    <= {drv & {3{redund_q}}, drv};
      lb_oe_n <= ~{drv & {3{redund_q}}, drv};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // line protocol state and flags
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lp_q <= transfer_reset_state;
      qcnt_q <= '0;
      sh_q <= 9'h000;
      col_q <= 8'h00;
      bitn_q <= 4'h0;
      first_q <= 1'b0;
      kind_q <= 1'b0;
      held_q <= 8'h00;
      have_q <= 1'b0;
      err_q <= 1'b0;
      msg_q <= 1'b0;
      send_q <= 1'b0;
      alarm_pend_q <= 1'b0;
    end else begin
      qcnt_q <= quiet ? (idle_seen ? qcnt_q : qcnt_q + 1'b1) : '0;
      if (wr_cmd && pb.wdata[CMD_ACK]) msg_q <= 1'b0;
      if (wr_cmd && pb.wdata[CMD_SEND]) send_q <= 1'b1;
      if (wr_acc && pb.addr == REG_ALARM) alarm_pend_q <= 1'b1;
      if (sw_rst) begin
        lp_q <= transfer_reset_state;
        err_q <= 1'b0;
        send_q <= 1'b0;
        alarm_pend_q <= 1'b0;
      end else if (mismatch || rx_bad) begin
        lp_q <= transfer_abort_state;
        err_q <= 1'b1;
      end else begin
        case (lp_q)
          transfer_reset_state: if (idle_seen) lp_q <= transfer_idle_state;
          transfer_idle_state: begin
            if (go) begin
              lp_q <= transfer_wait_state;
              if (alarm_pend_q) alarm_pend_q <= 1'b0;
              else send_q <= 1'b0;
            end else if (rise && ln_b && ln_d) begin
              lp_q <= transfer_wait_state;
              first_q <= 1'b1;
              bitn_q <= 4'h0;
              col_q <= 8'h00;
              have_q <= 1'b0;
            end
          end
          transfer_wait_state: begin
            if (tx_act) begin
              if (sym_end && tx_q == tx_stop_xfer) lp_q <= transfer_idle_state;
            end else if (rx_on && !ln_b) begin
              if (first_q) kind_q <= ln_d;
              else sh_q <= {ln_d, sh_q[8:1]};
              if (!first_q) bitn_q <= bitn_q + 4'h1;
              first_q <= 1'b0;
            end else if (stop_dt) begin
              held_q <= sh_q[7:0];
              have_q <= 1'b1;
              col_q <= col_q ^ sh_q[7:0];
              bitn_q <= 4'h0;
            end else if (stop_xf) begin
              lp_q <= transfer_idle_state;
              if (!kind_q) msg_q <= 1'b1; // set wins over ack
            end
          end
          default: lp_q <= lp_q;
        endcase
      end
    end
  end
endmodule // local_bus_interface

// ==== design/host_bus_processor.sv ====
// host end: axi4-lite command port, peripheral master, message buffer
`timescale 1ns/1ps
module host_bus_processor
  import lbi_pkg::*;
#(
  parameter int unsigned BUF_DEPTH = 16
) (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  lbi_periph_if.host       pb,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic      [1:0]  bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp
);
  typedef enum logic [1:0] {op_sw, op_poll, op_pop, op_ack} op_e;
  localparam int unsigned BW = $clog2(BUF_DEPTH);

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  logic [7:0]  aw_q;
  logic [31:0] w_q;
  logic        awh_q, wh_q;
  logic [11:0] cmd_q;
  logic        swp_q, done_q, sel_q;
  logic [7:0]  res_q, buf_q [BUF_DEPTH];
  logic [BW:0] cnt_q;
  op_e         op_q, nxt_q;
  wire wr_go   = awh_q & wh_q & ~bvalid;
  wire awh_d   = (awh_q | (awvalid & awready)) & ~wr_go;
  wire wh_d    = (wh_q | (wvalid & wready)) & ~wr_go;
  wire ar_go   = arvalid & arready;
  wire a_cmd   = (aw_q == H_CMD);
  wire a_clr   = (aw_q == H_BUF_STAT);
  wire r_buf   = (araddr[7:6] == H_BUF_BASE[7:6]) & (araddr[5:2] < 4'(BUF_DEPTH));
  wire w_ok    = a_cmd | a_clr;
  wire r_ok    = (araddr == H_RESULT) | (araddr == H_BUF_STAT) | r_buf;
  wire [31:0] r_mux = (araddr == H_RESULT)   ? {23'h0, swp_q, res_q} :
                      (araddr == H_BUF_STAT) ? {23'h0, done_q, 8'(cnt_q)} :
                      r_buf ? {24'h0, buf_q[araddr[BW+1:2]]} : 32'h0;
  wire sw_take = wr_go & a_cmd & (&wstrb[2:0]) & ~swp_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      awh_q <= 1'b0;
      wh_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
    end else begin
      awh_q <= awh_d;
      wh_q <= wh_d;
      if (awvalid && awready) aw_q <= awaddr;
      if (wvalid && wready) w_q <= wdata;
      awready <= ~awh_d & ~(awvalid & awready) & ~wr_go;
      wready <= ~wh_d & ~(wvalid & wready) & ~wr_go;
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= w_ok ? 2'h0 : 2'h2;
      end else if (bready) bvalid <= 1'b0;
      arready <= ~rvalid & ~ar_go;
      if (ar_go) begin
        rvalid <= 1'b1;
        rdata <= r_mux;
        rresp <= r_ok ? 2'h0 : 2'h2;
      end else if (rready) rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // peripheral master: software access first, else drain receive fifo
  wire ack_now = sel_q & pb.ack;
  assign pb.sel = sel_q;
  assign pb.wr = (op_q == op_sw) ? cmd_q[11] : (op_q == op_ack);
  assign pb.addr = (op_q == op_sw) ? cmd_q[10:8] :
                   (op_q == op_pop) ? REG_RXDATA : (op_q == op_ack) ? REG_CMD : REG_STATUS;
  assign pb.wdata = (op_q == op_sw) ? cmd_q[7:0] : 8'(1 << CMD_ACK);

  always_ff @(posedge mclk) begin
    if (ack_now && op_q == op_pop) buf_q[cnt_q[BW-1:0]] <= pb.rdata;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_q <= 12'h000;
      swp_q <= 1'b0;
      res_q <= 8'h00;
      sel_q <= 1'b0;
      op_q <= op_poll;
      nxt_q <= op_poll;
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      if (sw_take) begin
        cmd_q <= {w_q[H_CMD_WR], w_q[10:0]};
        swp_q <= 1'b1;
      end
      if (wr_go && a_clr && w_q[0] && !(sel_q && op_q == op_pop)) begin
        cnt_q <= '0;
        done_q <= 1'b0;
      end
      if (ack_now) begin
        sel_q <= 1'b0;
        case (op_q)
          op_sw: begin
            res_q <= pb.rdata;
            swp_q <= 1'b0;
          end
          op_poll: begin
            if (!pb.rdata[STAT_RXE] && cnt_q != (BW+1)'(BUF_DEPTH)) nxt_q <= op_pop;
            else if (pb.rdata[STAT_RXE] && pb.rdata[STAT_MSG]) nxt_q <= op_ack;
          end
          op_pop: begin
            cnt_q <= cnt_q + 1'b1;
            nxt_q <= op_poll;
          end
          default: begin
            done_q <= 1'b1;
            nxt_q <= op_poll;
          end
        endcase
      end else if (!sel_q) begin
        if (swp_q) begin
          op_q <= op_sw;
          sel_q <= 1'b1;
        end else if (!done_q) begin
          op_q <= nxt_q;
          sel_q <= 1'b1;
        end
      end
    end
  end
endmodule // host_bus_processor

// ==== dv/lbi_props.sv ====
// peripheral port checks between host end and device end
`timescale 1ns/1ps
module lbi_props
  import lbi_pkg::*;
(
  input wire logic       mclk,
  input wire logic       arst_n,
  input wire logic       sel,
  input wire logic       wr,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       ack
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
////////////////////////////////////////
  AST_ACK_NEXT: assert property (sel && !ack |=> ack)
    else $error("no ack after request");
  AST_ACK_PULSE: assert property (ack |=> !ack)
    else $error("ack too long");
  AST_SEL_DROP: assert property (ack |=> !sel)
    else $error("select held after ack");
  AST_ACK_CAUSE: assert property (ack |-> $past(sel))
    else $error("ack without request");
  AST_REQ_HOLD: assert property (sel && !ack |=> $stable({wr, addr, wdata}))
    else $error("request moved before ack");
  AST_RDATA_HOLD: assert property (!ack |-> $stable(rdata))
    else $error("read data moved without ack");
  AST_UNMAPPED: assert property (ack && $past(!wr && addr == 3'h7) |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_STATE_CODE: assert property (ack && $past(!wr && addr == REG_STATUS) |-> rdata[2:0] <= 3'h3)
    else $error("bad state code");
  AST_ABORT_ERR: assert property (ack && $past(!wr && addr == REG_STATUS)
    && rdata[2:0] == 3'h3 |-> rdata[STAT_ERR]) else $error("abort without error");
endmodule // lbi_props

// ==== dv/testbench.sv ====
// testbench: host end and device end joined, local bus looped back
`timescale 1ns/1ps
module testbench
  import lbi_pkg::*;
;
  logic        mclk, arst_n, awvalid, wvalid, bready, arvalid, rready, t_q;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, q[$], ex[$];
  logic [5:0]  lb_o, lb_oe_n, inj;
  logic [3:0]  strap_bus, strap_part;
  logic        strap_red;
  int          err_count, check_count, cyc, last, per;
  // wired-or: high while any party drives
  wire logic [5:0] lb_line = (~lb_oe_n & lb_o) | inj;
  lbi_periph_if pb_if ();
  host_bus_processor host_bus_processor_inst (.mclk, .arst_n, .pb(pb_if), .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
  local_bus_interface local_bus_interface_inst (.mclk, .arst_n, .pb(pb_if), .strap_bus_addr(strap_bus),
    .strap_part_addr(strap_part), .strap_redundant(strap_red), .lb_i(lb_line), .lb_o, .lb_oe_n);
  lbi_props lbi_props_inst (.mclk, .arst_n, .sel(pb_if.sel), .wr(pb_if.wr), .addr(pb_if.addr),
    .wdata(pb_if.wdata), .rdata(pb_if.rdata), .ack(pb_if.ack));
////////////////////////////////////////
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge mclk);
  endtask
  // one device access through the host command word
  task automatic dev(input logic w, input logic [2:0] i, input logic [7:0] v, output logic [7:0] o);
    logic [31:0] d;
    logic [1:0] r;
    axw(H_CMD, {15'h0, w, 5'h0, i, v});
    do axr(H_RESULT, d, r); while (d[8] !== 1'b0);
    o = d[7:0];
  endtask
  // expected {qualifier, data} per bit cycle of one element
  task automatic elem(input logic k, input logic [7:0] bs[$]);
    logic [7:0] c;
    c = 8'h00;
    ex.push_back(2'b11);
    ex.push_back({1'b0, k});
    foreach (bs[j]) c ^= bs[j];
    bs.push_back(c);
    foreach (bs[j]) begin
      for (int i = 0; i < 8; i++) ex.push_back({1'b0, bs[j][i]});
      ex.push_back({1'b0, ^bs[j]});
      ex.push_back(2'b10);
    end
    ex.push_back(2'b11);
  endtask
////////////////////////////////////////
  task automatic t_boot;
    logic [7:0] s;
    logic [31:0] d;
    logic [1:0] r;
    dev(1'b0, REG_STATUS, 8'h00, s);
    chk(s[2:0] === 3'h0, "not reset state");
    dev(1'b0, REG_STRAPS, 8'h00, s);
    chk(s === 8'h35, "straps");
    dev(1'b0, 3'h7, 8'h00, s);
    chk(s === 8'h00, "unmapped index");
    axr(8'h0c, d, r);
    chk(r === 2'b10 && d === 32'h0, "unmapped offset");
    repeat (IDLE_CYC) @(posedge mclk);
    dev(1'b0, REG_STATUS, 8'h00, s);
    chk(s[2:0] === 3'h1, "not idle");
    $display("boot test done");
  endtask
  task automatic t_send;
    logic [7:0] s;
    q.delete();
    elem(1'b1, '{8'h5a});
    elem(1'b0, '{8'hc3, 8'h81});
    dev(1'b1, REG_CTRL, 8'h01, s);
    dev(1'b1, REG_ALARM, 8'h5a, s);
    dev(1'b1, REG_TXDATA, 8'hc3, s);
    dev(1'b1, REG_TXDATA, 8'h81, s);
    dev(1'b1, REG_CMD, 8'h01, s);
    for (int n = 0; n < 60000 && q.size() < ex.size(); n++) @(posedge mclk);
    repeat (1000) @(posedge mclk);
    chk(q.size() == ex.size(), "bit count");
    foreach (ex[i]) chk(q[i] === ex[i], "bus bit");
    chk(per == 2 * HALF_AUTO, "bit period");
    dev(1'b0, REG_STATUS, 8'h00, s);
    chk(s === 8'h11, "status after send");
    $display("send test done");
  endtask
  task automatic t_fault;
    logic [7:0] s;
    q.delete();
    dev(1'b1, REG_CTRL, 8'h03, s);
    dev(1'b1, REG_TXDATA, 8'h00, s);
    dev(1'b1, REG_CMD, 8'h01, s);
    for (int n = 0; n < 20000 && q.size() < 3; n++) @(posedge mclk);
    chk(per == 2 * HALF_IBC, "slow period");
    inj <= 6'h04;
    repeat (4 * HALF_IBC) @(posedge mclk);
    inj <= 6'h00;
    @(posedge mclk);
    chk(lb_line === 6'h00, "not released");
    dev(1'b0, REG_STATUS, 8'h00, s);
    chk(s[3:0] === 4'hb, "no abort");
    dev(1'b1, REG_CMD, 8'h02, s);
    dev(1'b0, REG_STATUS, 8'h00, s);
    chk(s[2:0] === 3'h0, "abort kept");
    repeat (IDLE_CYC) @(posedge mclk);
    dev(1'b0, REG_STATUS, 8'h00, s);
    chk(s[2:0] === 3'h1, "not idle");
    $display("fault test done");
  endtask
  task automatic t_full;
    logic [7:0] s;
    logic [31:0] d;
    logic [1:0] r;
    dev(1'b1, REG_CTRL, 8'h00, s);
    for (int i = 0; i < 16; i++) dev(1'b1, REG_TXDATA, i[7:0], s);
    dev(1'b0, REG_STATUS, 8'h00, s);
    chk(s[STAT_TXF] === 1'b1 && s[STAT_RXE] === 1'b1, "fifo flags");
    dev(1'b0, REG_RXDATA, 8'h00, s);
    chk(s === 8'h00, "empty read");
    axr(H_BUF_STAT, d, r);
    chk(d[8:0] === 9'h0, "host buffer");
    $display("fifo test done");
  endtask
////////////////////////////////////////
  always @(posedge mclk) begin
    cyc++;
    if (lb_line[0] && !t_q) begin
      q.push_back({lb_line[1], lb_line[2]});
      chk(lb_line[5:3] === lb_line[2:0], "bus b differs");
      per = cyc - last;
      last = cyc;
    end
    t_q = lb_line[0];
  end
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    repeat (150000) @(posedge mclk);
    err_count++;
    stop_test();
  end
  initial begin
    {arst_n, awvalid, wvalid, bready, arvalid, rready, t_q} = '0;
    {awaddr, araddr, wdata, inj} = '0;
    wstrb = 4'hf;
    strap_bus = 4'h3;
    strap_part = 4'h5;
    strap_red = 1'b1;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    t_boot();
    t_send();
    t_fault();
    t_full();
    stop_test();
  end
endmodule // testbench
